// >>> pkg/lcdc_pkg.sv
// Constants, types and the register map of the character display command decoder.
// Assumes a single 200 MHz system clock and an Avalon-MM register slave with byte addresses.
package lcdc_pkg;

  // ************************************************************
  // Clock and execution times
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Times at the slowest oscillator setting, in ns
  localparam int unsigned CLEAR_TIME_NS = 1080000;   // 1.08 ms
  localparam int unsigned EXEC_TIME_NS = 26300;      // 26.3 us
  // Least times round up to whole cycles
  localparam int unsigned CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_W = 20;

  // ************************************************************
  // Register map (byte offsets)
  // ************************************************************
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] REG_CMD = 7'h00;
  localparam logic [6:0] REG_DATA = 7'h04;
  localparam logic [6:0] REG_CONFIG = 7'h08;
  localparam logic [6:0] REG_STATE = 7'h0c;
  localparam logic [6:0] REG_GLYPH = 7'h10;
  localparam logic [6:0] REG_ICON = 7'h14;
  localparam int unsigned ICON_WIN_BIT = 6;

  // ************************************************************
  // Memories, codes and icon geometry
  // ************************************************************
  localparam int unsigned DISPLAY_TEXT_RAM_DEPTH = 128;
  localparam int unsigned GLYPH_RAM_DEPTH = 64;
  localparam int unsigned ICON_DEPTH = 16;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [6:0] AC_HOME = 7'h00;
  localparam logic [6:0] FILL_LAST = 7'h7f;
  localparam logic [2:0] GLYPH_LAST_ROW = 3'h7;
  localparam logic [4:0] GLYPH_ROW_ALL = 5'h1f;
  localparam int unsigned ICON_SEGS = 80;
  localparam int unsigned ICON_PAIR_SEGS = 20;
  localparam int unsigned ICON_SEG_MAX = 100;
  localparam int unsigned SEGS_PER_ADDR = 5;
  localparam int unsigned SEG_TOP_BIT = 4;

  // ************************************************************
  // Instruction classes: position of the highest set bit
  // ************************************************************
  localparam logic [3:0] OP_CLEAR = 4'h0;
  localparam logic [3:0] OP_HOME = 4'h1;
  localparam logic [3:0] OP_ENTRY = 4'h2;
  localparam logic [3:0] OP_DISP = 4'h3;
  localparam logic [3:0] OP_SHIFT = 4'h4;
  localparam logic [3:0] OP_FUNC = 4'h5;
  localparam logic [3:0] OP_GLYPH_RAM = 4'h6;
  localparam logic [3:0] OP_DISPLAY_TEXT_RAM = 4'h7;
  localparam logic [3:0] OP_NONE = 4'h8;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS = 2'b10
  } lcdc_bus_e;

  typedef struct packed {
    logic glyph_sel;
    logic two_line;
    logic bus8;
    logic shift_en;
    logic inc;
    logic blink_on;
    logic cursor_on;
    logic display_on;
  } lcdc_mode_s;

  typedef struct packed {
    logic [6:0] pos;
    logic [2:0] row;
    logic [7:0] code;
  } lcdc_glyph_q_s;

endpackage : lcdc_pkg

// >>> verilog/lcdc_decoder.sv
// Instruction decoder, address counter and RAMs of a character display controller.
// Assumes an Avalon-MM master on the same clock and a strap pin from outside the clock domain.
//
// Overview of operation
// RL1 - Code bits 2..0 pick glyph slot
// RL2 - Row bits pick line; eighth ORs cursor
// RL3 - Data bits 4..0 are columns, 4 left
// RL4 - Upper code nibble zero selects glyph; bit3 ignored
// RL5 - Glyph bit one lights the pixel
// RL6 - Order one: icon segments ascend, pairs low
// RL7 - Order zero: icon segments run reversed
// RL8 - Instructions decoded only with strap high
// RL9 - Clear fills blanks, resets address counter
// RL10 - Home resets address and display shift
// RL11 - Entry mode sets direction and shift
// RL12 - Display control stores display, cursor, blink
// RL13 - Shift moves cursor or display only
// RL14 - Function set picks bus width, lines
// RL15 - Glyph address command loads six bits
// RL16 - Text address command loads seven bits
// RL17 - Status read gives busy and address
// RL18 - Data write stores, then address advances
// RL19 - Data read returns selected RAM byte
// RL20 - Host waits for not busy first
// RL21 - Busy holds for the execution time
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lcdc_decoder
  import lcdc_pkg::*;
#(
  parameter int unsigned CLEAR_CYCLES_P = CLEAR_CYCLES,
  parameter int unsigned EXEC_CYCLES_P = EXEC_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Strap and status
  input wire logic INSTRUCTION_SET_STRAP_I,
  output logic BUSY_O,
  output logic DISPLAY_ON_O
);

  // ************************************************************
  // State
  // ************************************************************
  logic strap_q1_r;
  logic strap_r;
  lcdc_bus_e bus_st_r;
  logic wait_r;
  logic [31:0] rdata_r;
  lcdc_mode_s mode_r;
  logic [6:0] ac_r;
  logic [6:0] shift_r;
  logic busy_r;
  logic [BUSY_W-1:0] busy_cnt_r;
  logic fill_r;
  logic [6:0] fill_idx_r;
  logic nib_r;
  logic [3:0] nib_hi_r;
  logic order_r;
  logic pair_r;
  lcdc_glyph_q_s gq_r;
  logic [6:0] iq_r;
  logic [7:0] display_text_ram_r [DISPLAY_TEXT_RAM_DEPTH];
  logic [7:0] glyph_ram_r [GLYPH_RAM_DEPTH];
  logic [7:0] icon_r [ICON_DEPTH];

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic req;
  logic start;
  logic done;
  logic is_cmd;
  logic is_data;
  logic is_icon;
  logic byte_done;
  logic [7:0] wbyte;
  logic [3:0] op;
  logic cmd_go;
  logic dwr_go;
  logic drd_go;
  logic [6:0] ac_step;
  logic [6:0] ac_adv;
  logic [6:0] shift_adv;
  logic [7:0] rd_byte;

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign start = req & (bus_st_r == BUS_IDLE);
  assign done = req & (bus_st_r == BUS_ANS);
  assign is_cmd = (AVS_ADDRESS_I == REG_CMD);
  assign is_data = (AVS_ADDRESS_I == REG_DATA);
  assign is_icon = AVS_ADDRESS_I[ICON_WIN_BIT];
  // In 4-bit mode a byte completes on the second access, high nibble first
  assign byte_done = done & (is_cmd | is_data) & (mode_r.bus8 | nib_r);
  assign wbyte = mode_r.bus8 ? AVS_WRITEDATA_I[7:0] : {nib_hi_r, AVS_WRITEDATA_I[7:4]};
  // Instruction and data accesses made while busy are dropped; the host is expected to poll first
  assign cmd_go = byte_done & AVS_WRITE_I & is_cmd & ~busy_r & strap_r; // RL8 RL20
  assign dwr_go = byte_done & AVS_WRITE_I & is_data & ~busy_r;
  assign drd_go = byte_done & AVS_READ_I & is_data & ~busy_r;
  assign ac_step = mode_r.inc ? 7'(ac_r + 7'h01) : 7'(ac_r - 7'h01);
  assign ac_adv = mode_r.glyph_sel ? {1'b0, ac_step[5:0]} : ac_step;
  assign shift_adv = mode_r.inc ? 7'(shift_r + 7'h01) : 7'(shift_r - 7'h01);

  function automatic logic [3:0] msb_pos(input logic [7:0] b);
    logic [3:0] p;
    p = OP_NONE;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction : msb_pos

  assign op = msb_pos(wbyte);

  // ************************************************************
  // Glyph and icon lookup
  // ************************************************************
  function automatic logic [8:0] glyph_row(input lcdc_glyph_q_s q);
    logic user;
    logic [4:0] px;
    user = (q.code[7:4] == 4'h0); // RL4
    px = glyph_ram_r[{q.code[2:0], q.row}][4:0]; // RL1 RL2 RL3
    if (q.row == GLYPH_LAST_ROW && mode_r.cursor_on && q.pos == ac_r && !mode_r.glyph_sel) begin
      px = px | GLYPH_ROW_ALL; // RL2
    end
    if (!user) begin
      px = 5'h00;
    end
    return {user, 3'h0, px}; // RL5
  endfunction : glyph_row

  function automatic logic icon_lit(input logic [6:0] seg);
    int s;
    int k;
    logic ok;
    s = int'(seg);
    k = 0;
    ok = 1'b0;
    if (order_r) begin
      if (s >= 1 && s <= ICON_SEGS) begin // RL6
        k = s - 1;
        ok = 1'b1;
      end else if (!pair_r && s > ICON_SEGS && s <= ICON_SEG_MAX) begin // RL6
        k = s - ICON_SEGS - 1;
        ok = 1'b1;
      end
    end else if (pair_r) begin
      if (s >= 1 && s <= ICON_SEGS) begin // RL7
        k = ICON_SEGS - s;
        ok = 1'b1;
      end
    end else if (s >= 1 && s <= ICON_PAIR_SEGS) begin // RL7
      k = ICON_PAIR_SEGS - s;
      ok = 1'b1;
    end else if (s > ICON_PAIR_SEGS && s <= ICON_SEG_MAX) begin // RL7
      k = ICON_SEG_MAX - s;
      ok = 1'b1;
    end
    return ok & icon_r[k / SEGS_PER_ADDR][SEG_TOP_BIT - (k % SEGS_PER_ADDR)];
  endfunction : icon_lit

  // ************************************************************
  // Strap synchroniser
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      strap_q1_r <= 1'b0;
      strap_r <= 1'b0;
    end else begin
      strap_q1_r <= INSTRUCTION_SET_STRAP_I;
      strap_r <= strap_q1_r;
    end
  end

  // ************************************************************
  // Avalon handshake and read data
  // ************************************************************
  // Byte read from RAM or status; idle RAM reads while busy give zero
  always_comb begin
    if (is_cmd) begin
      rd_byte = {busy_r, ac_r}; // RL17
    end else if (busy_r) begin
      rd_byte = 8'h00;
    end else if (mode_r.glyph_sel) begin
      rd_byte = glyph_ram_r[ac_r[5:0]]; // RL19
    end else begin
      rd_byte = display_text_ram_r[ac_r]; // RL19
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bus_st_r <= BUS_IDLE;
      wait_r <= 1'b1;
    end else begin
      case (bus_st_r)
        BUS_IDLE: begin
          if (start) begin
            bus_st_r <= BUS_ANS;
            wait_r <= 1'b0;
          end
        end
        BUS_ANS: begin
          bus_st_r <= BUS_IDLE;
          wait_r <= 1'b1;
        end
        default: begin
          bus_st_r <= BUS_IDLE;
          wait_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_r <= 32'h0;
    end else if (start && AVS_READ_I) begin
      if (is_cmd || is_data) begin
        if (mode_r.bus8) begin
          rdata_r <= {24'h0, rd_byte};
        end else begin
          rdata_r <= {24'h0, (nib_r ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};
        end
      end else if (is_icon) begin
        rdata_r <= {24'h0, icon_r[AVS_ADDRESS_I[5:2]]};
      end else if (AVS_ADDRESS_I == REG_CONFIG) begin
        rdata_r <= {30'h0, pair_r, order_r};
      end else if (AVS_ADDRESS_I == REG_STATE) begin
        rdata_r <= {8'h0, strap_r, shift_r, busy_r, ac_r, mode_r};
      end else if (AVS_ADDRESS_I == REG_GLYPH) begin
        rdata_r <= {23'h0, glyph_row(gq_r)};
      end else if (AVS_ADDRESS_I == REG_ICON) begin
        rdata_r <= {31'h0, icon_lit(iq_r)};
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end

  // ************************************************************
  // Software-side configuration and query registers
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      order_r <= 1'b1;
      pair_r <= 1'b1;
      gq_r <= '0;
      iq_r <= 7'h00;
    end else if (done && AVS_WRITE_I) begin
      if (AVS_ADDRESS_I == REG_CONFIG) begin
        order_r <= AVS_WRITEDATA_I[0];
        pair_r <= AVS_WRITEDATA_I[1];
      end else if (AVS_ADDRESS_I == REG_GLYPH) begin
        gq_r <= AVS_WRITEDATA_I[$bits(lcdc_glyph_q_s)-1:0];
      end else if (AVS_ADDRESS_I == REG_ICON) begin
        iq_r <= AVS_WRITEDATA_I[6:0];
      end
    end
  end

  // ************************************************************
  // Nibble pairing for the 4-bit bus
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      nib_r <= 1'b0;
      nib_hi_r <= 4'h0;
    end else if (mode_r.bus8) begin
      nib_r <= 1'b0;
    end else if (done && (is_cmd || is_data)) begin // RL14
      nib_r <= ~nib_r;
      if (!nib_r) begin
        nib_hi_r <= AVS_WRITEDATA_I[7:4];
      end
    end
  end

  // ************************************************************
  // Instruction execution: mode, address counter, display shift
  // ************************************************************
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mode_r <= '0;
      mode_r.bus8 <= 1'b1;
      mode_r.inc <= 1'b1;
      ac_r <= AC_HOME;
      shift_r <= 7'h00;
    end else if (cmd_go) begin
      case (op)
        OP_CLEAR: begin
          ac_r <= AC_HOME; // RL9
        end
        OP_HOME: begin
          ac_r <= AC_HOME; // RL10
          shift_r <= 7'h00;
        end
        OP_ENTRY: begin
          mode_r.inc <= wbyte[1]; // RL11
          mode_r.shift_en <= wbyte[0];
        end
        OP_DISP: begin
          mode_r.display_on <= wbyte[2]; // RL12
          mode_r.cursor_on <= wbyte[1];
          mode_r.blink_on <= wbyte[0];
        end
        OP_SHIFT: begin
          if (wbyte[3]) begin // RL13
            shift_r <= wbyte[2] ? 7'(shift_r + 7'h01) : 7'(shift_r - 7'h01);
          end else begin
            ac_r <= wbyte[2] ? 7'(ac_r + 7'h01) : 7'(ac_r - 7'h01);
          end
        end
        OP_FUNC: begin
          mode_r.bus8 <= wbyte[4]; // RL14
          mode_r.two_line <= wbyte[3];
        end
        OP_GLYPH_RAM: begin
          ac_r <= {1'b0, wbyte[5:0]}; // RL15
          mode_r.glyph_sel <= 1'b1;
        end
        OP_DISPLAY_TEXT_RAM: begin
          ac_r <= wbyte[6:0]; // RL16
          mode_r.glyph_sel <= 1'b0;
        end
        default: begin
          ac_r <= ac_r;
        end
      endcase
    end else if (dwr_go || drd_go) begin
      ac_r <= ac_adv; // RL11 RL18
      if (mode_r.shift_en) begin
        shift_r <= shift_adv; // RL11
      end
    end
  end

  // ************************************************************
  // Busy timer and clear fill
  // ************************************************************
  // Fill runs one entry a cycle; the clear busy time must cover all entries
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
      fill_r <= 1'b0;
      fill_idx_r <= 7'h00;
    end else begin
      if (cmd_go || dwr_go || drd_go) begin
        busy_r <= 1'b1; // RL21
        if (cmd_go && (op == OP_CLEAR || op == OP_HOME)) begin
          busy_cnt_r <= BUSY_W'(CLEAR_CYCLES_P - 1);
        end else begin
          busy_cnt_r <= BUSY_W'(EXEC_CYCLES_P - 1);
        end
      end else if (busy_r) begin
        if (busy_cnt_r == '0) begin
          busy_r <= 1'b0;
        end else begin
          busy_cnt_r <= busy_cnt_r - 1'b1;
        end
      end
      if (cmd_go && op == OP_CLEAR) begin
        fill_r <= 1'b1; // RL9
        fill_idx_r <= 7'h00;
      end else if (fill_r) begin
        fill_idx_r <= 7'(fill_idx_r + 7'h01);
        if (fill_idx_r == FILL_LAST) begin
          fill_r <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // RAM writes
  // ************************************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (fill_r) begin
      display_text_ram_r[fill_idx_r] <= BLANK_CODE; // RL9
    end else if (dwr_go && !mode_r.glyph_sel) begin
      display_text_ram_r[ac_r] <= wbyte; // RL18
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (dwr_go && mode_r.glyph_sel) begin
      glyph_ram_r[ac_r[5:0]] <= wbyte; // RL18
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (done && AVS_WRITE_I && is_icon) begin
      icon_r[AVS_ADDRESS_I[5:2]] <= AVS_WRITEDATA_I[7:0];
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign AVS_READDATA_O = rdata_r;
  assign AVS_WAITREQUEST_O = wait_r;
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BUSY_O <= 1'b0;
      DISPLAY_ON_O <= 1'b0;
    end else begin
      BUSY_O <= busy_r;
      DISPLAY_ON_O <= mode_r.display_on;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  busy_set_a: assert property ( // RL21
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (cmd_go || dwr_go || drd_go) |=> busy_r ##1 BUSY_O)
    else $error("busy not raised after accepted access");

  busy_hold_a: assert property ( // RL21
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (busy_r && busy_cnt_r != '0) |=> busy_r)
    else $error("busy dropped before its time");

  clear_ac_a: assert property ( // RL9
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (cmd_go && op == OP_CLEAR) |=> (ac_r == AC_HOME) && fill_r && busy_r)
    else $error("clear did not reset address and start fill");

  fill_end_a: assert property ( // RL9
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    $fell(busy_r) |-> !fill_r)
    else $error("busy ended while blank fill still running");

  home_a: assert property ( // RL10
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (cmd_go && op == OP_HOME) |=> (ac_r == AC_HOME) && (shift_r == 7'h00) && !fill_r)
    else $error("home did not reset address and shift");

  glyph_addr_a: assert property ( // RL15
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (cmd_go && op == OP_GLYPH_RAM) |=> mode_r.glyph_sel && (ac_r == {1'b0, $past(wbyte[5:0])}))
    else $error("glyph address command mis-loaded");

  text_addr_a: assert property ( // RL16
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (cmd_go && op == OP_DISPLAY_TEXT_RAM) |=> !mode_r.glyph_sel && (ac_r == $past(wbyte[6:0])))
    else $error("text address command mis-loaded");

  status_read_a: assert property ( // RL17
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (start && AVS_READ_I && is_cmd && mode_r.bus8) |=>
      !AVS_WAITREQUEST_O && (AVS_READDATA_O[7:0] == {$past(busy_r), $past(ac_r)}))
    else $error("status read wrong or late");

  data_adv_a: assert property ( // RL18
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (dwr_go && mode_r.inc && !mode_r.glyph_sel) |=> ac_r == 7'($past(ac_r) + 7'h01))
    else $error("address not advanced after data write");

  user_glyph_a: assert property ( // RL4
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (start && AVS_READ_I && AVS_ADDRESS_I == REG_GLYPH && gq_r.code[7:4] != 4'h0) |=>
      AVS_READDATA_O == 32'h0)
    else $error("non-user code returned glyph pixels");

  strap_gate_a: assert property ( // RL8
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (!strap_r && byte_done && AVS_WRITE_I && is_cmd) |=>
      (mode_r == $past(mode_r)) && (ac_r == $past(ac_r)))
    else $error("instruction executed with strap low");

endmodule : lcdc_decoder

`default_nettype wire

// >>> sim/lcdc_host.sv
// Host processor model: Avalon-MM master with a single-access task and a task that polls busy until clear.
// Assumes the decoder's one-cycle waitrequest answer on the same clock.
`timescale 1ns/1ps
`default_nettype none

module lcdc_host
  import lcdc_pkg::*;
(
  // Bus
  input wire logic clk_i,
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o
);
  initial begin
    addr_o = '0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = '0;
  end

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wr_o <= w;
      rd_o <= !w;
      wdata_o <= d;
      // No bound of its own: only the bench watchdog ends a hung wait
      do begin
        @(posedge clk_i);
      end while (wait_i !== 1'b0);
      q = rdata_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
    end
  endtask : acc

  // Polls status until the busy indicator reads 0
  task automatic rdy();
    logic [31:0] q;
    begin
      do acc(1'b0, REG_CMD, '0, q); while (q[7] !== 1'b0);
    end
  endtask : rdy
endmodule : lcdc_host

`default_nettype wire

// >>> sim/tb_lcdc_decoder.sv
// Self-checking bench of the display command decoder with a host model.
// Assumes short busy parameters; every scenario is one task.
`timescale 1ns/1ps
`default_nettype none

module tb_lcdc_decoder
  import lcdc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  logic busy;
  logic disp_on;
  logic [31:0] q;
  int n_fail = 0;
  int check_count = 0;

  always #2.5 clk = ~clk;

  lcdc_decoder #(.CLEAR_CYCLES_P(200), .EXEC_CYCLES_P(8)) dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .INSTRUCTION_SET_STRAP_I(strap), .BUSY_O(busy),
    .DISPLAY_ON_O(disp_on)
  );

  lcdc_host h (
    .clk_i(clk), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
    .wr_o(wr), .wdata_o(wdata)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic cmd(input logic [7:0] b);
    h.rdy();
    h.acc(1'b1, REG_CMD, {24'h0, b}, q);
  endtask : cmd

  task automatic dwr(input logic [7:0] b);
    h.rdy();
    h.acc(1'b1, REG_DATA, {24'h0, b}, q);
  endtask : dwr

  task automatic rdq(input logic [6:0] a);
    h.rdy();
    h.acc(1'b0, a, '0, q);
  endtask : rdq

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rdq(REG_STATE);
    chk(q[15:0], 32'h0028);
    rdq(7'h20);
    chk(q, 32'h0);
  endtask : t_reset

  task automatic t_clear();
    cmd(8'h01);
    h.acc(1'b0, REG_CMD, '0, q);
    chk(q[7], 1'b1);
    chk(busy, 1'b1);
    rdq(REG_CMD);
    chk(q[7:0], 8'h00);
    dwr(8'h41);
    rdq(REG_CMD);
    chk(q[7:0], 8'h01);
    cmd(8'h80);
    rdq(REG_DATA);
    chk(q[7:0], 8'h41);
    rdq(REG_DATA);
    chk(q[7:0], 8'h20);
  endtask : t_clear

  task automatic t_mode();
    cmd(8'h0e);
    cmd(8'h38);
    cmd(8'h04);
    cmd(8'h85);
    dwr(8'h33);
    rdq(REG_CMD);
    chk(q[7:0], 8'h04);
    rdq(REG_STATE);
    chk(q[7:0], 8'h63);
    chk(disp_on, 1'b1);
    cmd(8'h06);
  endtask : t_mode

  task automatic t_shift();
    cmd(8'h1c);
    rdq(REG_STATE);
    chk(q[22:16], 7'h01);
    cmd(8'h02);
    rdq(REG_STATE);
    chk(q[22:8], 15'h0);
    rdq(REG_DATA);
    chk(q[7:0], 8'h41);
    cmd(8'h10);
    rdq(REG_CMD);
    chk(q[7:0], 8'h00);
  endtask : t_shift

  task automatic t_glyph();
    cmd(8'h4a);
    dwr(8'h15);
    rdq(REG_STATE);
    chk(q[14:7], 8'h17);
    h.acc(1'b1, REG_GLYPH, 32'h0209, q);
    rdq(REG_GLYPH);
    chk(q[8:0], 9'h115);
    h.acc(1'b1, REG_GLYPH, 32'h0211, q);
    rdq(REG_GLYPH);
    chk(q[8], 1'b0);
    cmd(8'h80);
    h.acc(1'b1, REG_GLYPH, 32'h0701, q);
    rdq(REG_GLYPH);
    chk(q[4:0], 5'h1f);
  endtask : t_glyph

  task automatic icq(input logic [1:0] cfg, input logic [6:0] seg, input logic exp);
    h.acc(1'b1, REG_CONFIG, {30'h0, cfg}, q);
    h.acc(1'b1, REG_ICON, {25'h0, seg}, q);
    rdq(REG_ICON);
    chk(q[0], exp);
  endtask : icq

  task automatic t_icon();
    h.acc(1'b1, 7'h40, 32'h10, q);
    icq(2'h3, 7'd1, 1'b1);
    icq(2'h3, 7'd2, 1'b0);
    icq(2'h2, 7'd80, 1'b1);
    icq(2'h1, 7'd81, 1'b1);
    icq(2'h0, 7'd100, 1'b1);
  endtask : t_icon

  // Waits out the execution time; status reads pair up in 4-bit mode
  task automatic t_nib();
    cmd(8'h28);
    repeat (12) @(posedge clk);
    h.acc(1'b1, REG_CMD, 32'h80, q);
    h.acc(1'b1, REG_CMD, 32'h50, q);
    repeat (12) @(posedge clk);
    h.acc(1'b0, REG_CMD, '0, q);
    chk(q[7:0], 8'h00);
    h.acc(1'b0, REG_CMD, '0, q);
    chk(q[7:0], 8'h50);
    h.acc(1'b1, REG_CMD, 32'h30, q);
    h.acc(1'b1, REG_CMD, 32'h00, q);
    rdq(REG_CMD);
    chk(q[7:0], 8'h05);
  endtask : t_nib

  task automatic t_strap();
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(8'h08);
    h.rdy();
    chk(disp_on, 1'b1);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(8'h08);
    h.rdy();
    chk(disp_on, 1'b0);
  endtask : t_strap

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_clear();
    t_mode();
    t_shift();
    t_glyph();
    t_icon();
    t_nib();
    t_strap();
    end_sim();
  end

  // Whole run needs just over nine hundred cycles
  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
endmodule : tb_lcdc_decoder

`default_nettype wire
